// file: rtl/fwsp_device.sv
`timescale 1ns/100ps
module fwsp_device import fwsp_pkg::*; #(
    parameter int unsigned WRITE_CYCLES = STATUS_WRITE_CYCLES,
    parameter logic [23:0] IDENTITY = IDENTITY_DEFAULT
) (
    input wire logic clock,
    input wire logic resetn,
    fwsp_if.device link,
    input wire logic array_busy,
    input wire logic array_done,
    output logic write_latch_flag,
    output logic busy_flag,
    output logic [2:0] block_guard_bits,
    output logic chip_wipe_allowed,
    output logic hard_lock_mode
);
    typedef enum logic [7:0] {
        DS_IDLE = 8'b00000001,
        DS_OPC = 8'b00000010,
        DS_LATCH = 8'b00000100,
        DS_ID = 8'b00001000,
        DS_STAT = 8'b00010000,
        DS_WDATA = 8'b00100000,
        DS_WFULL = 8'b01000000,
        DS_DROP = 8'b10000000
    } fwsp_dstate_e;

    logic [2:0] sck_sync;
    logic [2:0] cs_sync;
    logic [1:0] mosi_sync;
    logic [1:0] wp_sync;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic selected;

    fwsp_dstate_e state_reg, state_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] opc_reg, opc_next;
    logic [7:0] pend_reg, pend_next;
    logic miso_reg, miso_next;
    logic oe_n_reg, oe_n_next;
    logic wel_reg, wel_next;
    logic [2:0] guard_reg, guard_next;
    logic lock_reg, lock_next;
    logic wip_reg, wip_next;
    logic [15:0] timer_reg, timer_next;
    logic [7:0] sh;
    logic [7:0] status_byte;
    logic busy;
    logic hard_lock;

    // Pins cross two flops before any logic looks at them
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sck_sync <= 3'h0;
            cs_sync <= 3'h7;
            mosi_sync <= 2'h0;
            wp_sync <= 2'h3;
        end else begin
            sck_sync <= {sck_sync[1:0], link.sck};
            cs_sync <= {cs_sync[1:0], link.cs_n};
            mosi_sync <= {mosi_sync[0], link.mosi};
            wp_sync <= {wp_sync[0], link.write_protect_n};
        end
    end

    assign sck_rise = sck_sync[1] & ~sck_sync[2];
    assign sck_fall = ~sck_sync[1] & sck_sync[2];
    assign cs_fall = ~cs_sync[1] & cs_sync[2];
    assign cs_rise = cs_sync[1] & ~cs_sync[2];
    assign selected = ~cs_sync[1];

    assign busy = wip_reg | array_busy;
    assign hard_lock = lock_reg & ~wp_sync[1];
    always_comb begin
        status_byte = 8'h00;
        status_byte[ST_BUSY] = busy;
        status_byte[ST_WEL] = wel_reg;
        status_byte[ST_GUARD_HI:ST_GUARD_LO] = guard_reg;
        status_byte[ST_LOCK] = lock_reg;
    end

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        opc_next = opc_reg;
        pend_next = pend_reg;
        miso_next = miso_reg;
        oe_n_next = oe_n_reg;
        wel_next = wel_reg;
        guard_next = guard_reg;
        lock_next = lock_reg;
        wip_next = wip_reg;
        timer_next = timer_reg;
        sh = {shift_reg[6:0], mosi_sync[1]};
        if (array_done) begin
            wel_next = 1'b0;
        end
        // Self-timed status write; new guard values land at the end
        if (wip_reg) begin
            if (timer_reg == 16'h0000) begin
                wip_next = 1'b0;
                wel_next = 1'b0;
                guard_next = pend_reg[ST_GUARD_HI:ST_GUARD_LO];
                lock_next = pend_reg[ST_LOCK];
            end else begin
                timer_next = timer_reg - 16'h0001;
            end
        end
        if (cs_fall) begin
            state_next = DS_OPC;
            cnt_next = 5'h00;
        end else if (cs_rise) begin
            case (state_reg)
                DS_LATCH: begin
                    if (opc_reg == OPC_SET_LATCH) begin
                        wel_next = 1'b1;
                    end else begin
                        wel_next = 1'b0;
                    end
                end
                DS_WFULL: begin
                    // Refused silently: no latch, locked with pin low, or busy
                    if (wel_reg && !hard_lock && !busy) begin
                        wip_next = 1'b1;
                        timer_next = 16'(WRITE_CYCLES - 1);
                    end
                end
                default: begin
                end
            endcase
            state_next = DS_IDLE;
            oe_n_next = 1'b1;
        end else if (selected && sck_rise) begin
            shift_next = sh;
            cnt_next = cnt_reg + 5'h01;
            case (state_reg)
                DS_OPC: begin
                    if (cnt_reg == BYTE_LAST) begin
                        cnt_next = 5'h00;
                        opc_next = sh;
                        // Only status reads get through a running cycle
                        if (busy && sh != OPC_READ_STAT) begin
                            state_next = DS_DROP;
                        end else if (sh == OPC_SET_LATCH || sh == OPC_CLR_LATCH) begin
                            state_next = DS_LATCH;
                        end else if (sh == OPC_READ_ID) begin
                            state_next = DS_ID;
                        end else if (sh == OPC_READ_STAT) begin
                            state_next = DS_STAT;
                        end else if (sh == OPC_WRITE_STAT) begin
                            state_next = DS_WDATA;
                        end else begin
                            state_next = DS_DROP;
                        end
                    end
                end
                DS_LATCH: begin
                    state_next = DS_DROP;
                end
                DS_ID: begin
                    if (cnt_reg == ID_END) begin
                        cnt_next = cnt_reg;
                    end
                end
                DS_WDATA: begin
                    if (cnt_reg == BYTE_LAST) begin
                        pend_next = sh;
                        state_next = DS_WFULL;
                    end
                end
                DS_WFULL: begin
                    state_next = DS_DROP;
                end
                default: begin
                end
            endcase
        end else if (selected && sck_fall) begin
            case (state_reg)
                DS_ID: begin
                    oe_n_next = 1'b0;
                    if (cnt_reg <= ID_LAST) begin
                        miso_next = IDENTITY[ID_LAST - cnt_reg];
                    end else begin
                        miso_next = 1'b0;
                    end
                end
                DS_STAT: begin
                    oe_n_next = 1'b0;
                    // Live value each bit, repeating every byte
                    miso_next = status_byte[3'h7 - cnt_reg[2:0]];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= DS_IDLE;
            cnt_reg <= 5'h00;
            shift_reg <= 8'h00;
            opc_reg <= 8'h00;
            pend_reg <= 8'h00;
            miso_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            wel_reg <= 1'b0;
            guard_reg <= GUARD_RESET;
            lock_reg <= LOCK_RESET;
            wip_reg <= 1'b0;
            timer_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            opc_reg <= opc_next;
            pend_reg <= pend_next;
            miso_reg <= miso_next;
            oe_n_reg <= oe_n_next;
            wel_reg <= wel_next;
            guard_reg <= guard_next;
            lock_reg <= lock_next;
            wip_reg <= wip_next;
            timer_reg <= timer_next;
        end
    end

    assign link.miso_out = miso_reg;
    assign link.miso_oe_n = oe_n_reg;
    assign write_latch_flag = wel_reg;
    assign busy_flag = busy;
    assign block_guard_bits = guard_reg;
    assign chip_wipe_allowed = wel_reg & (guard_reg == 3'h0);
    assign hard_lock_mode = hard_lock;
endmodule

// file: rtl/fwsp_host.sv
`timescale 1ns/100ps
module fwsp_host import fwsp_pkg::*; #(
    parameter int unsigned HALF = SCK_HALF_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    fwsp_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_opcode,
    input wire logic [7:0] cmd_data,
    input wire logic [1:0] cmd_bytes,
    input wire logic protect_level,
    output logic rsp_valid,
    output logic [23:0] rsp_data
);
    typedef enum logic [4:0] {
        HS_IDLE = 5'b00001,
        HS_LOW = 5'b00010,
        HS_HIGH = 5'b00100,
        HS_TAIL = 5'b01000,
        HS_GAP = 5'b10000
    } fwsp_hstate_e;

    localparam logic [7:0] HALF_LOAD = 8'(HALF - 1);

    logic [1:0] miso_sync;
    fwsp_hstate_e state_reg, state_next;
    logic [7:0] div_reg, div_next;
    logic [5:0] bit_reg, bit_next;
    logic [5:0] nbits_reg, nbits_next;
    logic [31:0] tx_reg, tx_next;
    logic [23:0] rx_reg, rx_next;
    logic cs_n_reg, cs_n_next;
    logic sck_reg, sck_next;
    logic mosi_reg, mosi_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [23:0] rsp_data_reg, rsp_data_next;
    logic wp_reg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            miso_sync <= 2'h3;
            wp_reg <= 1'b1;
        end else begin
            miso_sync <= {miso_sync[0], link.miso};
            wp_reg <= protect_level;
        end
    end

    assign cmd_ready = (state_reg == HS_IDLE);

    always_comb begin
        state_next = state_reg;
        div_next = div_reg;
        bit_next = bit_reg;
        nbits_next = nbits_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        cs_n_next = cs_n_reg;
        sck_next = sck_reg;
        mosi_next = mosi_reg;
        rsp_valid_next = 1'b0;
        rsp_data_next = rsp_data_reg;
        case (state_reg)
            HS_IDLE: begin
                if (cmd_valid) begin
                    // Frame is the opcode byte plus cmd_bytes more bytes, cmd_data first
                    tx_next = {cmd_opcode, cmd_data, 16'h0000};
                    nbits_next = {3'({1'b0, cmd_bytes} + 3'h1), 3'h0};
                    bit_next = 6'h00;
                    rx_next = 24'h000000;
                    cs_n_next = 1'b0;
                    mosi_next = cmd_opcode[7];
                    div_next = HALF_LOAD;
                    state_next = HS_LOW;
                end
            end
            HS_LOW: begin
                if (div_reg == 8'h00) begin
                    sck_next = 1'b1;
                    div_next = HALF_LOAD;
                    state_next = HS_HIGH;
                end else begin
                    div_next = div_reg - 8'h01;
                end
            end
            HS_HIGH: begin
                if (div_reg == 8'h00) begin
                    // Device drove this bit one whole period ago
                    if (bit_reg >= 6'h08) begin
                        rx_next = {rx_reg[22:0], miso_sync[1]};
                    end
                    bit_next = bit_reg + 6'h01;
                    sck_next = 1'b0;
                    div_next = HALF_LOAD;
                    tx_next = {tx_reg[30:0], 1'b0};
                    mosi_next = tx_reg[30];
                    if (bit_reg == nbits_reg - 6'h01) begin
                        state_next = HS_TAIL;
                    end else begin
                        state_next = HS_LOW;
                    end
                end else begin
                    div_next = div_reg - 8'h01;
                end
            end
            HS_TAIL: begin
                if (div_reg == 8'h00) begin
                    cs_n_next = 1'b1;
                    rsp_valid_next = 1'b1;
                    rsp_data_next = rx_reg;
                    div_next = HALF_LOAD;
                    state_next = HS_GAP;
                end else begin
                    div_next = div_reg - 8'h01;
                end
            end
            default: begin
                if (div_reg == 8'h00) begin
                    state_next = HS_IDLE;
                end else begin
                    div_next = div_reg - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= HS_IDLE;
            div_reg <= 8'h00;
            bit_reg <= 6'h00;
            nbits_reg <= 6'h00;
            tx_reg <= 32'h00000000;
            rx_reg <= 24'h000000;
            cs_n_reg <= 1'b1;
            sck_reg <= 1'b0;
            mosi_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= 24'h000000;
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            bit_reg <= bit_next;
            nbits_reg <= nbits_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            cs_n_reg <= cs_n_next;
            sck_reg <= sck_next;
            mosi_reg <= mosi_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg <= rsp_data_next;
        end
    end

    assign link.cs_n = cs_n_reg;
    assign link.sck = sck_reg;
    assign link.mosi = mosi_reg;
    assign link.write_protect_n = wp_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_data = rsp_data_reg;
endmodule

// file: rtl/fwsp_if.sv
`timescale 1ns/100ps
interface fwsp_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic write_protect_n;
    logic miso_out;
    logic miso_oe_n;
    logic miso;
    // Pull-up while the device leaves the line undriven
    assign miso = miso_oe_n ? 1'b1 : miso_out;
    modport device (
        input cs_n,
        input sck,
        input mosi,
        input write_protect_n,
        output miso_out,
        output miso_oe_n
    );
    modport host (
        output cs_n,
        output sck,
        output mosi,
        output write_protect_n,
        input miso
    );
endinterface

// file: rtl/fwsp_pkg.sv
package fwsp_pkg;
    // Instruction codes
    localparam logic [7:0] OPC_SET_LATCH = 8'h06;
    localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
    localparam logic [7:0] OPC_READ_ID = 8'h9F;
    localparam logic [7:0] OPC_READ_STAT = 8'h05;
    localparam logic [7:0] OPC_WRITE_STAT = 8'h01;
    // Status byte layout
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_GUARD_LO = 2;
    localparam int ST_GUARD_HI = 4;
    localparam int ST_LOCK = 7;
    localparam logic [2:0] GUARD_RESET = 3'h0;
    localparam logic LOCK_RESET = 1'b0;
    // Identity value is arbitrary
    localparam logic [23:0] IDENTITY_DEFAULT = 24'hA55A3C;
    localparam logic [4:0] ID_LAST = 5'h17;
    localparam logic [4:0] ID_END = 5'h18;
    localparam logic [4:0] BYTE_LAST = 5'h07;
    // Timing
    localparam int unsigned CLOCK_KHZ = 40000;
    localparam int unsigned STATUS_WRITE_NS = 5000;
    localparam int unsigned STATUS_WRITE_CYCLES =
        (STATUS_WRITE_NS * CLOCK_KHZ + 999999) / 1000000;
    localparam int unsigned SCK_HALF_CYCLES = 4;
endpackage

// file: verification/flash_write_enable_status_protect_test.sv
`timescale 1ns/100ps
module flash_write_enable_status_protect_test import fwsp_pkg::*;;
    logic clock = 1'b0;
    logic resetn, cmd_valid, cmd_ready, protect_level, rsp_valid, array_busy, array_done;
    logic [7:0] cmd_opcode, cmd_data;
    logic [1:0] cmd_bytes;
    logic [23:0] rsp_data;
    logic write_latch_flag, busy_flag, chip_wipe_allowed, hard_lock_mode, wel_b, busy_b;
    logic [2:0] block_guard_bits, guard_b;
    int err_total = 0;
    int checked = 0;
    fwsp_if link();
    fwsp_if bad();
    fwsp_host i_fwsp_host (.clock, .resetn, .link(link.host), .cmd_valid, .cmd_ready,
        .cmd_opcode, .cmd_data, .cmd_bytes, .protect_level, .rsp_valid, .rsp_data);
    fwsp_device i_fwsp_device (.clock, .resetn, .link(link.device), .array_busy, .array_done,
        .write_latch_flag, .busy_flag, .block_guard_bits, .chip_wipe_allowed, .hard_lock_mode);
    // Second device faces a hand-driven host that breaks framing on purpose
    fwsp_device i_fwsp_device_bad (.clock, .resetn, .link(bad.device), .array_busy(1'b0),
        .array_done(1'b0), .write_latch_flag(wel_b), .busy_flag(busy_b),
        .block_guard_bits(guard_b), .chip_wipe_allowed(), .hard_lock_mode());
    fwsp_monitor i_fwsp_monitor (.clock, .resetn, .cs_n(link.cs_n), .sck(link.sck),
        .mosi(link.mosi), .miso_out(link.miso_out), .miso_oe_n(link.miso_oe_n), .array_busy,
        .write_latch_flag, .busy_flag, .block_guard_bits, .chip_wipe_allowed, .hard_lock_mode);
    always #12.5 clock = ~clock;
    task chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task test_done;
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task note(input string name);
        $display("Test %s ended, mismatches so far %0d", name, err_total);
    endtask
    task cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task cmd(input logic [7:0] op, input logic [7:0] data, input logic [1:0] n);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 50) begin
            cycles(1);
            k++;
        end
        chk(24'(cmd_ready), 24'h1, "host never ready");
        cmd_opcode = op;
        cmd_data = data;
        cmd_bytes = n;
        cmd_valid = 1'b1;
        cycles(1);
        cmd_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 1000) begin
            cycles(1);
            k++;
        end
        chk(24'(k < 1000), 24'h1, "no response from host");
        // Leaves room for the device synchroniser and the deselect gap
        cycles(12);
    endtask
    task rd_stat(input logic [7:0] exp);
        cmd(OPC_READ_STAT, 8'h00, 2'h1);
        chk(24'(rsp_data[7:0]), 24'(exp), "status byte");
    endtask
    task wait_idle;
        int k;
        k = 0;
        while (busy_flag !== 1'b0 && k < 400) begin
            cycles(1);
            k++;
        end
        chk(24'(busy_flag), 24'h0, "busy never ended");
    endtask
    // Half period of 4 clocks gives the 200 ns link clock, edges just after a rising edge
    task bang(input logic [15:0] bits, input int n);
        bad.cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            bad.mosi = bits[15 - i];
            cycles(4);
            bad.sck = 1'b1;
            cycles(4);
            bad.sck = 1'b0;
        end
        cycles(4);
        bad.cs_n = 1'b1;
        bad.mosi = ~bad.mosi;
        cycles(40);
    endtask
    task t_basic;
        chk(24'(write_latch_flag), 24'h0, "latch after reset");
        rd_stat(8'h00);
        cmd(OPC_SET_LATCH, 8'h00, 2'h0);
        chk(24'(write_latch_flag), 24'h1, "latch set");
        // Unknown opcode must leave the latch alone
        cmd(8'h5A, 8'h00, 2'h0);
        rd_stat(8'h02);
        cmd(OPC_CLR_LATCH, 8'h00, 2'h0);
        chk(24'(write_latch_flag), 24'h0, "latch clear");
        cmd(OPC_READ_ID, 8'h00, 2'h3);
        chk(rsp_data, IDENTITY_DEFAULT, "identity");
        cmd(OPC_READ_ID, 8'h00, 2'h1);
        chk(24'(rsp_data[7:0]), 24'(IDENTITY_DEFAULT[23:16]), "identity cut");
        rd_stat(8'h00);
        note("basic");
    endtask
    task t_write;
        cmd(OPC_WRITE_STAT, 8'h9C, 2'h1);
        chk(24'(busy_flag), 24'h0, "write taken with latch clear");
        cmd(OPC_SET_LATCH, 8'h00, 2'h0);
        cmd(OPC_WRITE_STAT, 8'hFF, 2'h2);
        chk(24'(busy_flag), 24'h0, "overlong write taken");
        cmd(OPC_WRITE_STAT, 8'hFF, 2'h1);
        rd_stat(8'h03);
        wait_idle;
        chk(24'(block_guard_bits), 24'h7, "guards written");
        cmd(OPC_READ_STAT, 8'h00, 2'h3);
        chk(rsp_data, 24'h9C9C9C, "repeated status");
        cmd(OPC_SET_LATCH, 8'h00, 2'h0);
        chk(24'(chip_wipe_allowed), 24'h0, "wipe with guards");
        note("write");
    endtask
    task t_hard;
        protect_level = 1'b0;
        cycles(8);
        chk(24'(hard_lock_mode), 24'h1, "hard lock entry");
        cmd(OPC_WRITE_STAT, 8'h00, 2'h1);
        chk(24'(busy_flag), 24'h0, "write in hard lock");
        chk(24'(block_guard_bits), 24'h7, "guards in hard lock");
        protect_level = 1'b1;
        cycles(8);
        chk(24'(hard_lock_mode), 24'h0, "hard lock exit");
        cmd(OPC_SET_LATCH, 8'h00, 2'h0);
        cmd(OPC_WRITE_STAT, 8'h00, 2'h1);
        wait_idle;
        rd_stat(8'h00);
        cmd(OPC_SET_LATCH, 8'h00, 2'h0);
        chk(24'(chip_wipe_allowed), 24'h1, "wipe with guards clear");
        cmd(OPC_CLR_LATCH, 8'h00, 2'h0);
        chk(24'(write_latch_flag), 24'h0, "latch clear again");
        note("hard");
    endtask
    task t_busy;
        array_busy = 1'b1;
        rd_stat(8'h01);
        // Undriven line reads as the pull-up level
        cmd(OPC_READ_ID, 8'h00, 2'h3);
        chk(rsp_data, 24'hFFFFFF, "identity while busy");
        cmd(OPC_SET_LATCH, 8'h00, 2'h0);
        chk(24'(write_latch_flag), 24'h0, "latch set while busy");
        array_busy = 1'b0;
        cmd(OPC_SET_LATCH, 8'h00, 2'h0);
        chk(24'(write_latch_flag), 24'h1, "latch set after busy");
        array_done = 1'b1;
        cycles(1);
        array_done = 1'b0;
        cycles(2);
        chk(24'(write_latch_flag), 24'h0, "latch after array cycle");
        note("busy");
    endtask
    task t_frame;
        bang(16'h0600, 9);
        chk(24'(wel_b), 24'h0, "latch set off boundary");
        bang(16'h0600, 8);
        chk(24'(wel_b), 24'h1, "latch set on boundary");
        bang(16'h011C, 15);
        chk(24'(busy_b), 24'h0, "short write taken");
        bang(16'h011C, 16);
        chk(24'(busy_b), 24'h1, "write not started");
        cycles(300);
        chk(24'(guard_b), 24'h7, "bad link guards");
        note("frame");
    endtask
    initial begin
        resetn = 1'b0;
        {cmd_valid, cmd_opcode, cmd_data, cmd_bytes, array_busy, array_done} = '0;
        protect_level = 1'b1;
        {bad.cs_n, bad.sck, bad.mosi, bad.write_protect_n} = 4'h9;
        cycles(12);
        resetn = 1'b1;
        cycles(4);
        t_basic;
        t_write;
        t_hard;
        t_busy;
        t_frame;
        test_done;
    end
    // Run needs about 120 us; the limit leaves generous margin
    initial begin
        #1000000;
        err_total++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        test_done;
    end
endmodule

// file: verification/fwsp_monitor.sv
`timescale 1ns/100ps
module fwsp_monitor import fwsp_pkg::*; #(
    parameter int unsigned WRITE_CYCLES = STATUS_WRITE_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso_out,
    input wire logic miso_oe_n,
    input wire logic array_busy,
    input wire logic write_latch_flag,
    input wire logic busy_flag,
    input wire logic [2:0] block_guard_bits,
    input wire logic chip_wipe_allowed,
    input wire logic hard_lock_mode
);
    logic [31:0] busy_cnt_reg;
    logic [31:0] busy_cnt_next;
    // Array activity restarts the count, so only timed status writes are measured
    always_comb begin
        busy_cnt_next = (busy_flag && !array_busy) ? busy_cnt_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_cnt_reg <= 32'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    select_idle_a: assert property (cs_n |-> !sck)
        else $error("serial clock moved while deselected");
    mosi_steady_a: assert property ($rose(sck) |-> $stable(mosi))
        else $error("host data changed at sampling edge");
    miso_steady_a: assert property (sck && $past(sck) |-> $stable(miso_out))
        else $error("device data changed while clock high");
    line_release_a: assert property (cs_n [*8] |-> miso_oe_n)
        else $error("device still drives output when deselected");
    latch_rise_a: assert property ($rose(write_latch_flag) |-> cs_n && !busy_flag)
        else $error("latch set outside a completed frame");
    latch_needed_a: assert property ($rose(busy_flag) && !array_busy |-> write_latch_flag)
        else $error("timed write started with latch clear");
    end_clears_a: assert property ($fell(busy_flag) && !$past(array_busy) |-> !write_latch_flag)
        else $error("latch not cleared at end of timed write");
    busy_span_a: assert property ($fell(busy_flag) && !$past(array_busy) |->
        busy_cnt_reg + 32'h1 >= WRITE_CYCLES && busy_cnt_reg <= WRITE_CYCLES + 32'h2)
        else $error("timed write length wrong");
    guard_source_a: assert property (!$stable(block_guard_bits) |-> $fell(busy_flag))
        else $error("guard bits changed outside write completion");
    lock_frozen_a: assert property (hard_lock_mode && $past(hard_lock_mode) |->
        $stable(block_guard_bits))
        else $error("guard bits changed in hard lock");
    // Only a fresh latch set may open the wipe, and only with every guard clear
    wipe_gate_a: assert property ($rose(chip_wipe_allowed) |->
        $rose(write_latch_flag) && block_guard_bits == 3'h0)
        else $error("chip wipe allowed with guards set");
endmodule
